// ==== rtl/fpec_top.sv ====
// Flash program/erase controller with control and unlock key registers
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

// How it works
// - Start bit launches timed operation, hardware clears
// - Software can set start, never clear it
// - Enable bit one allows, zero blocks operations
// - Improper start or termination sets error flag
// - Erase select picks erase versus program
// - Command 1010xx erases whole boot block
// - Command 1001xx erases entire memory
// - Commands 011000/011001/011010 erase 1/2/4 rows
// - Command 0101xx erases configuration block
// - Command 0011xx erases general memory block
// - Program with 0001xx writes one row
// - Command 0100xx erases EEPROM, other encodings do nothing
// - Row target comes from table pointer
// - Boot and chip erase need serial mode
// - Program-only bit affects EEPROM, exists if present
// - Control bits 11 to 7 read zero
// - Program address is 24 bits wide
// - User accesses stay in lower half
// - Table ops reach configuration with page bit 7
module fpec_top
  import fpec_pkg::*;
#(
  parameter bit EEPROM_PRESENT = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic serialProgMode,
  input wire logic opAbort,
  input wire logic [7:0] tablePage,
  input wire logic [15:0] tableOffset,
  input wire logic tableReadOp,
  input wire logic tableWriteOp,
  input wire logic fetchActive,
  input wire logic [22:0] progCounter,
  input wire logic remapActive,
  input wire logic [7:0] remapPage,
  input wire logic [15:0] remapOffset,
  output logic [23:0] progAddr,
  output logic progAddrValid,
  output logic progAddrDenied,
  output logic memActive,
  output fpec_op_e memOp,
  output logic [23:0] memRowAddr,
  output logic [2:0] memRowCount,
  output logic memEraseFirst,
  output logic memDone
);
  fpec_seq_if seq ();

  logic startBit;
  logic enableBit;
  logic errFlag;
  logic progOnly;
  logic eraseSel;
  logic [5:0] cmdField;
  logic [7:0] keyReg;
  fpec_lock_e lockState;
  logic ctrlWr;
  logic keyWr;
  logic startReq;
  logic modeOk;
  logic launch;
  logic eraseLaunch;
  logic termOp;
  logic errSet;
  logic next_progOnly;
  logic eepromTarget;
  logic [23:0] tableAddr;
  logic [23:0] remapAddr;
  logic [15:0] ctrlView;

  fpec_cmd_decode u_decode (
    .seq(seq.decode)
  );

  fpec_op_timer u_timer (
    .clk(clk),
    .rst(rst),
    .seq(seq.timer)
  );

  assign ctrlWr = regWr && (regAddr == CTRL_OFFSET);
  assign keyWr = regWr && (regAddr == KEY_OFFSET);
  assign tableAddr = {tablePage, tableOffset};
  assign remapAddr = {remapPage, remapOffset};

  // Decoder sees the command being written, else the stored one
  assign seq.erase = ctrlWr ? regWrData[ERASE_BIT] : eraseSel;
  assign seq.cmd = ctrlWr ? regWrData[CMD_MSB:CMD_LSB] : cmdField;
  assign seq.serialMode = serialProgMode;

  assign startReq = ctrlWr && regWrData[START_BIT] && !startBit;
  assign modeOk = !seq.privileged || seq.serialMode;
  // Launch needs the armed key, the enable bit and a legal mode
  assign launch = startReq && (lockState == LOCK_ARMED) && regWrData[ENABLE_BIT] && modeOk;
  assign eraseLaunch = launch && regWrData[ERASE_BIT];
  assign termOp = startBit && opAbort;
  assign errSet = (startReq && !launch) || termOp;
  assign seq.load = launch;
  assign seq.abort = termOp;

  assign next_progOnly = regWrData[PROG_ONLY_BIT] && EEPROM_PRESENT;
  assign eepromTarget = (tableAddr >= EEPROM_BASE) && !tableAddr[USER_TOP_BIT];

  // Unimplemented bits read back as zero
  assign ctrlView = {startBit, enableBit, errFlag, progOnly, 5'h00, eraseSel, cmdField};

  // Unlock key sequence tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      keyReg <= KEY_RESET;
      lockState <= LOCK_IDLE;
    end else if (keyWr) begin
      keyReg <= regWrData[KEY_MSB:0];
      unique case (lockState)
        LOCK_IDLE: lockState <= (regWrData[KEY_MSB:0] == KEY_FIRST) ? LOCK_HALF : LOCK_IDLE;
        LOCK_HALF: lockState <= (regWrData[KEY_MSB:0] == KEY_SECOND) ? LOCK_ARMED :
                                (regWrData[KEY_MSB:0] == KEY_FIRST) ? LOCK_HALF : LOCK_IDLE;
        LOCK_ARMED: lockState <= (regWrData[KEY_MSB:0] == KEY_FIRST) ? LOCK_HALF : LOCK_IDLE;
      endcase
    end else if (regWr) begin
      lockState <= LOCK_IDLE;
    end
  end

  // Start bit: set by a good launch, cleared only by hardware
  always_ff @(posedge clk) begin
    if (rst) begin
      startBit <= 1'b0;
    end else if (launch) begin
      startBit <= 1'b1;
    end else if (seq.done || termOp) begin
      startBit <= 1'b0;
    end
  end

  // Error flag: hardware set wins over a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      errFlag <= 1'b0;
    end else if (errSet) begin
      errFlag <= 1'b1;
    end else if (ctrlWr) begin
      errFlag <= regWrData[ERROR_BIT];
    end
  end

  // Command fields are frozen while an operation runs
  always_ff @(posedge clk) begin
    if (rst) begin
      enableBit <= 1'b0;
      progOnly <= 1'b0;
      eraseSel <= 1'b0;
      cmdField <= 6'h00;
    end else if (ctrlWr) begin
      enableBit <= regWrData[ENABLE_BIT];
      if (!startBit) begin
        progOnly <= next_progOnly;
        eraseSel <= regWrData[ERASE_BIT];
        cmdField <= regWrData[CMD_MSB:CMD_LSB];
      end
    end
  end

  // Operation handed to the memory array
  always_ff @(posedge clk) begin
    if (rst) begin
      memActive <= 1'b0;
      memOp <= OP_NONE;
      memRowAddr <= 24'h000000;
      memRowCount <= 3'h0;
      memEraseFirst <= 1'b0;
      memDone <= 1'b0;
    end else begin
      memDone <= seq.done;
      if (launch) begin
        memActive <= 1'b1;
        memOp <= seq.opKind;
        memRowAddr <= tableAddr;
        memRowCount <= seq.rowCount;
        memEraseFirst <= !(next_progOnly && eepromTarget);
      end else if (seq.done || termOp) begin
        memActive <= 1'b0;
      end
    end
  end

  // Program space address formation
  always_ff @(posedge clk) begin
    if (rst) begin
      progAddr <= 24'h000000;
      progAddrValid <= 1'b0;
      progAddrDenied <= 1'b0;
    end else begin
      progAddrValid <= 1'b0;
      progAddrDenied <= 1'b0;
      if (tableReadOp || tableWriteOp) begin
        progAddr <= tableAddr;
        progAddrValid <= 1'b1;
      end else if (remapActive) begin
        progAddr <= remapAddr;
        progAddrValid <= !remapAddr[USER_TOP_BIT];
        progAddrDenied <= remapAddr[USER_TOP_BIT];
      end else if (fetchActive) begin
        progAddr <= {1'b0, progCounter};
        progAddrValid <= 1'b1;
      end
    end
  end

  // Register read port, data valid the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      unique case (regAddr)
        CTRL_OFFSET: regRdData <= ctrlView;
        KEY_OFFSET: regRdData <= {8'h00, keyReg};
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  start_launch_a: assert property (@(posedge clk) disable iff (rst)
    launch |=> startBit && memActive ##1 startBit)
    else $error("start bit did not follow a launch");

  start_clear_a: assert property (@(posedge clk) disable iff (rst)
    seq.done |=> !startBit && !memActive && memDone)
    else $error("start bit not cleared at completion");

  no_sw_clear_a: assert property (@(posedge clk) disable iff (rst)
    (startBit && ctrlWr && !regWrData[START_BIT] && !seq.done && !opAbort) |=> startBit)
    else $error("software cleared the start bit");

  program_erase_enable_block_a: assert property (@(posedge clk) disable iff (rst)
    (startReq && !regWrData[ENABLE_BIT]) |=> !startBit && errFlag)
    else $error("start allowed with enable low");

  bad_seq_a: assert property (@(posedge clk) disable iff (rst)
    (startReq && lockState != LOCK_ARMED) |=> errFlag && !memActive)
    else $error("improper sequence not flagged");

  abort_err_a: assert property (@(posedge clk) disable iff (rst)
    termOp |=> errFlag && !startBit)
    else $error("terminated operation not flagged");

  row_write_a: assert property (@(posedge clk) disable iff (rst)
    (launch && !regWrData[ERASE_BIT] && regWrData[5:2] == CMD_ROW_WRITE)
      |=> memOp == OP_ROW_WRITE && memRowCount == COUNT_ONE)
    else $error("row write not selected");

  row_addr_a: assert property (@(posedge clk) disable iff (rst)
    launch |=> memRowAddr == $past(tableAddr))
    else $error("row address not from table pointer");

  serial_mode_a: assert property (@(posedge clk) disable iff (rst)
    (startReq && seq.privileged && !serialProgMode) |=> !startBit && errFlag)
    else $error("privileged erase outside serial mode");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    (regRd && regAddr == CTRL_OFFSET) |=> regRdData[RSVD_MSB:RSVD_LSB] == 5'h00)
    else $error("unimplemented bits read nonzero");

  user_half_a: assert property (@(posedge clk) disable iff (rst)
    (remapActive && !tableReadOp && !tableWriteOp) |=> !(progAddrValid && progAddr[23]))
    else $error("user access reached upper half");

  reset_zero_a: assert property (@(posedge clk)
    rst |=> ctrlView == CTRL_RESET && keyReg == KEY_RESET)
    else $error("registers not zero after reset");

  active_mirror_a: assert property (@(posedge clk) disable iff (rst)
    memActive == startBit)
    else $error("busy output differs from start bit");

  done_pulse_a: assert property (@(posedge clk) disable iff (rst)
    memDone |=> !memDone)
    else $error("completion pulse longer than one cycle");

  timer_busy_a: assert property (@(posedge clk) disable iff (rst)
    startBit |-> seq.busy || seq.done)
    else $error("start bit set with no timed operation");

  abort_stop_a: assert property (@(posedge clk) disable iff (rst)
    (termOp && !seq.done) |=> !memActive && !memDone)
    else $error("terminated operation still active");

  start_hold_a: assert property (@(posedge clk) disable iff (rst)
    (startBit && !seq.done && !termOp) |=> startBit)
    else $error("start bit dropped without hardware cause");

  enable_wr_a: assert property (@(posedge clk) disable iff (rst)
    ctrlWr |=> enableBit == $past(regWrData[ENABLE_BIT]))
    else $error("enable bit not written");

  good_start_a: assert property (@(posedge clk) disable iff (rst)
    (launch && !regWrData[ERROR_BIT]) |=> !errFlag)
    else $error("proper sequence flagged as error");

  prog_side_a: assert property (@(posedge clk) disable iff (rst)
    (launch && !regWrData[ERASE_BIT]) |=> memOp == OP_ROW_WRITE || memOp == OP_NONE)
    else $error("program select started an erase");

  boot_op_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:2] == CMD_BOOT_ERASE) |=> memOp == OP_BOOT_ERASE)
    else $error("boot block erase not selected");

  chip_op_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:2] == CMD_CHIP_ERASE) |=> memOp == OP_CHIP_ERASE)
    else $error("whole memory erase not selected");

  row_four_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:0] == 6'h1A)
      |=> memOp == OP_ROW_ERASE && memRowCount == COUNT_FOUR)
    else $error("four row erase not selected");

  cfg_op_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:2] == CMD_CFG_ERASE) |=> memOp == OP_CFG_ERASE)
    else $error("configuration erase not selected");

  eeprom_op_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:2] == CMD_EEPROM_ERASE) |=> memOp == OP_EEPROM_ERASE)
    else $error("data memory erase not selected");

  general_op_a: assert property (@(posedge clk) disable iff (rst)
    (eraseLaunch && regWrData[5:2] == CMD_GENERAL_ERASE) |=> memOp == OP_GENERAL_ERASE)
    else $error("general block erase not selected");

  nop_prog_a: assert property (@(posedge clk) disable iff (rst)
    (launch && !regWrData[ERASE_BIT] && regWrData[5:2] != CMD_ROW_WRITE)
      |=> memOp == OP_NONE)
    else $error("unlisted program command did something");

  table_addr_a: assert property (@(posedge clk) disable iff (rst)
    (tableReadOp || tableWriteOp) |=> progAddrValid && progAddr == $past(tableAddr))
    else $error("table access address not formed");

  fetch_addr_a: assert property (@(posedge clk) disable iff (rst)
    (fetchActive && !remapActive && !tableReadOp && !tableWriteOp)
      |=> progAddrValid && progAddr == {1'b0, $past(progCounter)})
    else $error("fetch address not formed");

  remap_deny_a: assert property (@(posedge clk) disable iff (rst)
    (remapActive && !tableReadOp && !tableWriteOp && remapAddr[USER_TOP_BIT])
      |=> progAddrDenied && !progAddrValid)
    else $error("upper half remap access not refused");
endmodule

// ==== pkg/fpec_pkg.sv ====
// Constants and types for the flash program/erase controller
package fpec_pkg;
  localparam logic [15:0] CTRL_OFFSET = 16'h0760;
  localparam logic [15:0] KEY_OFFSET = 16'h0766;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam int START_BIT = 15;
  localparam int ENABLE_BIT = 14;
  localparam int ERROR_BIT = 13;
  localparam int PROG_ONLY_BIT = 12;
  localparam int RSVD_MSB = 11;
  localparam int RSVD_LSB = 7;
  localparam int ERASE_BIT = 6;
  localparam int CMD_MSB = 5;
  localparam int CMD_LSB = 0;
  localparam int KEY_MSB = 7;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [3:0] CMD_BOOT_ERASE = 4'hA;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h9;
  localparam logic [3:0] CMD_ROW_ERASE = 4'h6;
  localparam logic [3:0] CMD_CFG_ERASE = 4'h5;
  localparam logic [3:0] CMD_EEPROM_ERASE = 4'h4;
  localparam logic [3:0] CMD_GENERAL_ERASE = 4'h3;
  localparam logic [3:0] CMD_ROW_WRITE = 4'h1;
  localparam logic [1:0] ROWS_ONE = 2'h0;
  localparam logic [1:0] ROWS_TWO = 2'h1;
  localparam logic [1:0] ROWS_FOUR = 2'h2;
  localparam logic [2:0] COUNT_ONE = 3'h1;
  localparam logic [2:0] COUNT_TWO = 3'h2;
  localparam logic [2:0] COUNT_FOUR = 3'h4;
  localparam int CNT_W = 12;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ROW_TIME_NS = 100000;
  localparam int BULK_TIME_NS = 200000;
  localparam logic [CNT_W-1:0] ROW_CYCLES = CNT_W'(ROW_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BULK_CYCLES = CNT_W'(BULK_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] NOP_CYCLES = 12'h001;
  localparam logic [23:0] EEPROM_BASE = 24'h7FFE00;
  localparam int USER_TOP_BIT = 23;
  localparam int CFG_PAGE_BIT = 7;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BOOT_ERASE,
    OP_CHIP_ERASE,
    OP_ROW_ERASE,
    OP_CFG_ERASE,
    OP_EEPROM_ERASE,
    OP_GENERAL_ERASE,
    OP_ROW_WRITE
  } fpec_op_e;
  typedef enum logic [1:0] {LOCK_IDLE, LOCK_HALF, LOCK_ARMED} fpec_lock_e;
  typedef logic [CNT_W-1:0] fpec_cnt_t;
endpackage

// ==== pkg/fpec_seq_if.sv ====
// Signals between the controller, its command decoder and its operation timer
`timescale 1ns/1ps
interface fpec_seq_if;
  import fpec_pkg::*;
  logic erase;
  logic [5:0] cmd;
  logic serialMode;
  fpec_op_e opKind;
  logic [2:0] rowCount;
  fpec_cnt_t opCycles;
  logic privileged;
  logic load;
  logic abort;
  logic busy;
  logic done;
  modport decode (input erase, cmd, serialMode, output opKind, rowCount, opCycles, privileged);
  modport timer (input load, opCycles, abort, output busy, done);
  modport ctrl (output erase, cmd, serialMode, load, abort,
                input opKind, rowCount, opCycles, privileged, busy, done);
endinterface

// ==== rtl/fpec_cmd_decode.sv ====
// Decoder from erase select and command field to operation, rows and duration
`timescale 1ns/1ps
module fpec_cmd_decode
  import fpec_pkg::*;
(
  fpec_seq_if.decode seq
);
  function automatic logic cmd_is(input logic [5:0] cmd, input logic [3:0] hi);
    return cmd[5:2] == hi;
  endfunction

  always_comb begin
    seq.opKind = OP_NONE;
    seq.rowCount = 3'h0;
    seq.opCycles = NOP_CYCLES;
    seq.privileged = 1'b0;
    if (seq.erase) begin
      if (cmd_is(seq.cmd, CMD_BOOT_ERASE)) begin
        seq.opKind = OP_BOOT_ERASE;
        seq.opCycles = BULK_CYCLES;
        seq.privileged = 1'b1;
      end else if (cmd_is(seq.cmd, CMD_CHIP_ERASE)) begin
        seq.opKind = OP_CHIP_ERASE;
        seq.opCycles = BULK_CYCLES;
        seq.privileged = 1'b1;
      end else if (cmd_is(seq.cmd, CMD_ROW_ERASE)) begin
        case (seq.cmd[1:0])
          ROWS_ONE: seq.rowCount = COUNT_ONE;
          ROWS_TWO: seq.rowCount = COUNT_TWO;
          ROWS_FOUR: seq.rowCount = COUNT_FOUR;
          default: seq.rowCount = 3'h0;
        endcase
        if (seq.rowCount != 3'h0) begin
          seq.opKind = OP_ROW_ERASE;
          seq.opCycles = ROW_CYCLES;
        end
      end else if (cmd_is(seq.cmd, CMD_CFG_ERASE)) begin
        seq.opKind = OP_CFG_ERASE;
        seq.opCycles = BULK_CYCLES;
      end else if (cmd_is(seq.cmd, CMD_EEPROM_ERASE)) begin
        seq.opKind = OP_EEPROM_ERASE;
        seq.opCycles = BULK_CYCLES;
      end else if (cmd_is(seq.cmd, CMD_GENERAL_ERASE)) begin
        seq.opKind = OP_GENERAL_ERASE;
        seq.opCycles = BULK_CYCLES;
      end
    end else if (cmd_is(seq.cmd, CMD_ROW_WRITE)) begin
      seq.opKind = OP_ROW_WRITE;
      seq.rowCount = COUNT_ONE;
      seq.opCycles = ROW_CYCLES;
    end
    // Anything else stays a one-cycle no operation
  end
endmodule

// ==== rtl/fpec_op_timer.sv ====
// Self-timing counter for one program or erase operation
`timescale 1ns/1ps
module fpec_op_timer
  import fpec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  fpec_seq_if.timer seq
);
  fpec_cnt_t remain;

  always_ff @(posedge clk) begin
    if (rst) begin
      remain <= '0;
      seq.busy <= 1'b0;
      seq.done <= 1'b0;
    end else begin
      seq.done <= 1'b0;
      if (seq.abort) begin
        remain <= '0;
        seq.busy <= 1'b0;
      end else if (seq.load) begin
        remain <= seq.opCycles;
        seq.busy <= 1'b1;
      end else if (seq.busy) begin
        if (remain == NOP_CYCLES) begin
          remain <= '0;
          seq.busy <= 1'b0;
          seq.done <= 1'b1;
        end else begin
          remain <= remain - NOP_CYCLES;
        end
      end
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
module tb_top
  import fpec_pkg::*;
;
  logic clk, rst, regWr, regRd, serialProgMode, opAbort;
  logic tableReadOp, tableWriteOp, fetchActive, remapActive;
  logic [15:0] regAddr, regWrData, tableOffset, remapOffset, regRdData;
  logic [7:0] tablePage, remapPage;
  logic [22:0] progCounter;
  logic [23:0] progAddr, memRowAddr;
  logic progAddrValid, progAddrDenied, memActive, memEraseFirst, memDone;
  fpec_op_e memOp;
  logic [2:0] memRowCount;
  int num_errors;
  int cmp_count;
  int n;
  logic [6:0] tCmd [9] = '{7'h68, 7'h64, 7'h58, 7'h59, 7'h5A, 7'h54, 7'h50, 7'h4C, 7'h04};
  fpec_op_e tOp [9] = '{OP_BOOT_ERASE, OP_CHIP_ERASE, OP_ROW_ERASE, OP_ROW_ERASE, OP_ROW_ERASE,
    OP_CFG_ERASE, OP_EEPROM_ERASE, OP_GENERAL_ERASE, OP_ROW_WRITE};
  logic [2:0] tCnt [9] = '{3'h0, 3'h0, COUNT_ONE, COUNT_TWO, COUNT_FOUR, 3'h0, 3'h0, 3'h0,
    COUNT_ONE};

  fpec_top i_fpec_top (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serialProgMode(serialProgMode),
    .opAbort(opAbort), .tablePage(tablePage), .tableOffset(tableOffset),
    .tableReadOp(tableReadOp), .tableWriteOp(tableWriteOp), .fetchActive(fetchActive),
    .progCounter(progCounter), .remapActive(remapActive), .remapPage(remapPage),
    .remapOffset(remapOffset), .progAddr(progAddr), .progAddrValid(progAddrValid),
    .progAddrDenied(progAddrDenied), .memActive(memActive), .memOp(memOp),
    .memRowAddr(memRowAddr), .memRowCount(memRowCount), .memEraseFirst(memEraseFirst),
    .memDone(memDone));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(24'(regRdData), 24'(exp));
  endtask

  // Unlock pair then control write on consecutive cycles; returns in the first busy cycle
  task automatic go(input logic [15:0] ctrl);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= KEY_OFFSET;
    regWrData <= {8'h00, KEY_FIRST};
    @(posedge clk);
    regWrData <= {8'h00, KEY_SECOND};
    @(posedge clk);
    regAddr <= CTRL_OFFSET;
    regWrData <= ctrl;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask

  // Terminate a running operation and clear the flags again
  task automatic stop(input logic [15:0] ctrl);
    @(posedge clk);
    opAbort <= 1'b1;
    @(posedge clk);
    opAbort <= 1'b0;
    #1;
    chk(24'(memActive), 24'h0);
    rdChk(CTRL_OFFSET, (ctrl & 16'h507F) | 16'h2000);
    wr(CTRL_OFFSET, 16'h0000);
  endtask

  task automatic waitDone(output int cyc);
    for (cyc = 0; cyc < 5000 && memDone !== 1'b1; cyc++) begin
      @(posedge clk);
      #1;
    end
    if (memDone !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: completion never seen", $time);
      tally_and_finish();
    end
  endtask

  task automatic ap(input logic [3:0] sel, input logic [23:0] expA, input logic expV);
    @(posedge clk);
    {tableReadOp, tableWriteOp, remapActive, fetchActive} <= sel;
    @(posedge clk);
    {tableReadOp, tableWriteOp, remapActive, fetchActive} <= 4'h0;
    #1;
    chk(24'(progAddrValid), 24'(expV));
    chk(24'(progAddrDenied), 24'(!expV));
    if (expV) begin
      chk(progAddr, expA);
    end
  endtask

  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    {regWr, regRd, serialProgMode, opAbort} = 4'h0;
    {tableReadOp, tableWriteOp, fetchActive, remapActive} = 4'h0;
    {regAddr, regWrData, tableOffset, remapOffset} = 64'h0;
    {tablePage, remapPage} = 16'h0;
    progCounter = 23'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(24'(memActive), 24'h0);
    rdChk(CTRL_OFFSET, CTRL_RESET);
    rdChk(KEY_OFFSET, 16'h0000);
    rdChk(16'h0762, 16'h0000);
    wr(CTRL_OFFSET, 16'h7FFF);
    rdChk(CTRL_OFFSET, 16'h707F);
    wr(CTRL_OFFSET, 16'h0000);
    wr(CTRL_OFFSET, 16'hC058);
    rdChk(CTRL_OFFSET, 16'h6058);
    wr(CTRL_OFFSET, 16'h0000);
    go(16'h8058);
    chk(24'(memActive), 24'h0);
    rdChk(CTRL_OFFSET, 16'h2058);
    wr(CTRL_OFFSET, 16'h0000);
    go(16'hC068);
    chk(24'(memActive), 24'h0);
    rdChk(CTRL_OFFSET, 16'h6068);
    wr(CTRL_OFFSET, 16'h0000);
    tablePage <= 8'h01;
    tableOffset <= 16'h0200;
    go(16'hC059);
    chk(24'(memOp), 24'(OP_ROW_ERASE));
    chk(24'(memRowCount), 24'(COUNT_TWO));
    chk(memRowAddr, 24'h010200);
    waitDone(n);
    chk(24'(n), 24'(ROW_CYCLES) + 24'h000001);
    @(posedge clk);
    #1;
    chk(24'(memActive), 24'h0);
    chk(24'(memDone), 24'h0);
    rdChk(CTRL_OFFSET, 16'h4059);
    go(16'hC018);
    chk(24'(memOp), 24'(OP_NONE));
    waitDone(n);
    rdChk(CTRL_OFFSET, 16'h4018);
    wr(CTRL_OFFSET, 16'h0000);
    serialProgMode <= 1'b1;
    tableOffset <= 16'h0400;
    for (int i = 0; i < 9; i++) begin
      go({9'h180, tCmd[i]});
      chk(24'(memActive), 24'h1);
      chk(24'(memOp), 24'(tOp[i])); // Operation kind
      chk(24'(memRowCount), 24'(tCnt[i])); // Row count
      rdChk(CTRL_OFFSET, {9'h180, tCmd[i]});
      wr(CTRL_OFFSET, {9'h080, tCmd[i]});
      rdChk(CTRL_OFFSET, {9'h180, tCmd[i]});
      stop({9'h180, tCmd[i]});
    end
    tablePage <= 8'h7F;
    tableOffset <= 16'hFE10;
    go(16'hD004);
    chk(24'(memEraseFirst), 24'h0);
    stop(16'hD004);
    go(16'hC004);
    chk(24'(memEraseFirst), 24'h1);
    stop(16'hC004);
    tablePage <= 8'h80;
    tableOffset <= 16'h0004;
    ap(4'h8, 24'h800004, 1'b1);
    ap(4'h4, 24'h800004, 1'b1);
    remapPage <= 8'h80;
    remapOffset <= 16'h1234;
    ap(4'h2, 24'h0, 1'b0);
    remapPage <= 8'h12;
    ap(4'h2, 24'h121234, 1'b1);
    progCounter <= 23'h7ABCDE;
    ap(4'h1, 24'h7ABCDE, 1'b1);
    tally_and_finish();
  end
endmodule
